/* File: diag_pkg.sv */
/*
 Shared constants for the output point diagnostics block: register map,
 field positions, reset values and timing counts.
 Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package diag_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int NPTS = 16;               // Output points
   localparam int AW = 8;                  // Decoded address bits
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CMD = 8'h00;     // Commanded values
   localparam logic [7:0] OFS_CFG = 8'h04;     // Configuration
   localparam logic [7:0] OFS_RPI = 8'h08;     // Packet interval, ms
   localparam logic [7:0] OFS_ECHO = 8'h0c;    // Applied values
   localparam logic [7:0] OFS_OPEN = 8'h10;    // Open-load flags
   localparam logic [7:0] OFS_OVC = 8'h14;     // Overcurrent flags
   localparam logic [7:0] OFS_PWR = 8'h18;     // Power-loss flags
   localparam logic [7:0] OFS_ISTS = 8'h1c;    // Event status
   localparam logic [7:0] OFS_IMSK = 8'h20;    // Event mask
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int CFG_PWR_MON = 0;         // Power-loss monitor enable
   localparam int CFG_OPEN_EN = 1;         // Open-load check enable
   localparam int IEV_PACKET = 0;          // Packet sent
   localparam int IEV_OPEN = 1;            // New open load
   localparam int IEV_OVC = 2;             // New overcurrent
   localparam int IEV_PWR = 3;             // New power loss
   localparam int NEV = 4;                 // Event count
   localparam logic [1:0] CFG_RST = 2'h0;  // Both checks off
   localparam logic [15:0] RPI_RST = 16'h000a; // 10 ms
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;      // 100 MHz
   localparam int MS_NS = 1000000;         // One millisecond
   localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   localparam int OPEN_QUAL_MS = 250;      // Off time before open load
   localparam logic [7:0] OPEN_QUAL_TICKS = 8'(OPEN_QUAL_MS);
endpackage

/* File: point_diag_if.sv */
/*
 Carrier between the diagnostics top and its open-load timer.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface point_diag_if;
   logic ms_tick;           // One-cycle millisecond pulse
   logic open_en;           // Open-load check enabled
   logic [15:0] drive;      // Applied output values
   logic [15:0] sense;      // Synchronised open-load sense
   logic [15:0] qual;       // Qualified open-load per point
   modport top (output ms_tick, open_en, drive, sense, input qual);
   modport timer (input ms_tick, open_en, drive, sense, output qual);
endinterface

/* File: open_load_timer.sv */
/*
 Per-point off-time counters that qualify open-load sense.
 Assumes a millisecond tick from the top and synchronised sense inputs.
*/
`timescale 1ns/1ps
module open_load_timer
   import diag_pkg::*;
(
   input wire logic hclk,            // System clock
   input wire logic hresetn,         // Async reset, low
   point_diag_if.timer pd            // Link to the top
);
   // ----------------------------------------------------------------
   // Off-time counters
   // ----------------------------------------------------------------
   logic [7:0] cnt_q [NPTS];         // Milliseconds off, saturating
   logic [15:0] qual_q;              // Qualified flags

   // Count only while off; any on time restarts the count (see RULE13)
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NPTS; i++) begin
            cnt_q[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < NPTS; i++) begin
            if (pd.drive[i]) begin
               cnt_q[i] <= 8'h00;                     // see RULE13
            end else if (pd.ms_tick && cnt_q[i] != OPEN_QUAL_TICKS) begin
               cnt_q[i] <= cnt_q[i] + 8'h01;
            end
         end
      end
   end

   // Flag only when enabled, off and qualified (see RULE5, RULE6, RULE7)
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         qual_q <= 16'h0000;
      end else begin
         for (int i = 0; i < NPTS; i++) begin
            qual_q[i] <= pd.open_en && !pd.drive[i] && pd.sense[i] &&
                         cnt_q[i] == OPEN_QUAL_TICKS;
         end
      end
   end

   assign pd.qual = qual_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_qual_after_time: assert property (@(posedge hclk) disable iff (!hresetn)
      qual_q[0] |-> $past(cnt_q[0]) == OPEN_QUAL_TICKS) // see RULE7
      else $error("open load flagged before qualification time");
   a_count_restarts: assert property (@(posedge hclk) disable iff (!hresetn)
      pd.drive[0] |=> cnt_q[0] == 8'h00 && !qual_q[0]) // see RULE13
      else $error("off counter not restarted by on command");
endmodule

/* File: output_point_diagnostics.sv */
/*
 Diagnostics for a 16-point digital output port: value echo, periodic
 status packets, field power loss, open load, short and thermal shutoff.
 Assumes an AHB-Lite master on hclk, fault pins from the field side that
 are asynchronous, and a controller that reads the packet outputs.
*/
// The implementer's own choices: the register offsets and the AHB-Lite register port.
// Notes on behaviour
// RULE1 - Echo applied terminal value of every point
// RULE2 - Send echo and status each packet interval
// RULE3 - Flag every point when field power fails
// RULE4 - Power loss reported only while monitoring on
// RULE5 - Check open load only while point off
// RULE6 - Open-load check off after reset until enabled
// RULE7 - Open load needs 250 ms continuous off
// RULE8 - Open-load flag is one while detected
// RULE9 - Short: output off, red indicator, flag set
// RULE10 - Short cleared: resume command, indicator off, clear
// RULE11 - Overtemperature: output off, red indicator, flag set
// RULE12 - Temperature normal: restart, indicator off, clear flag
// RULE13 - Per-point off counter restarts on every on
`timescale 1ns/1ps
module output_point_diagnostics
   import diag_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF // Cycles per ms
) (
   input wire logic hclk,                  // System clock
   input wire logic hresetn,               // Async reset, low
   input wire logic hsel,                  // Slave select
   input wire logic [31:0] haddr,          // Byte address
   input wire logic [1:0] htrans,          // Transfer type
   input wire logic hwrite,                // Write when high
   input wire logic [2:0] hsize,           // Word only
   input wire logic [31:0] hwdata,         // Write data
   input wire logic hready,                // Bus ready
   output logic [31:0] hrdata,             // Read data
   output logic hreadyout,                 // Always ready
   output logic hresp,                     // Always OKAY
   input wire logic field_power_ok,        // Field supply present, pin
   input wire logic [15:0] short_det,      // Short sense, pins
   input wire logic [15:0] over_temp,      // Thermal sense, pins
   input wire logic [15:0] open_sense,     // Open-load sense, pins
   output logic [15:0] pt_drive,           // Terminal drive
   output logic [15:0] led_red,            // Point indicators, red
   output logic [15:0] point_open_load_flag,  // Open load per point
   output logic [15:0] point_overcurrent_flag, // Short or thermal
   output logic [15:0] point_power_fault,  // Power loss per point
   output logic packet_strobe,             // One-cycle packet pulse
   output logic [15:0] packet_echo,        // Echo snapshot
   output logic [15:0] packet_open_load,   // Open-load snapshot
   output logic [15:0] packet_overcurrent, // Overcurrent snapshot
   output logic [15:0] packet_power_fault, // Power-loss snapshot
   output logic irq                        // Level interrupt
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [48:0] meta_q;                    // First stage, read by sync only
   logic [48:0] sync_q;                    // Second stage
   logic pwr_ok_s;                         // Field power present
   logic [15:0] trip_s;                    // Short or thermal shutoff

   // Two flops on every pin before any logic sees it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= {1'b1, 48'h0};
         sync_q <= {1'b1, 48'h0};
      end else begin
         meta_q <= {field_power_ok, short_det, over_temp, open_sense};
         sync_q <= meta_q;
      end
   end

   assign pwr_ok_s = sync_q[48];
   // Short and thermal share one shutoff path (see RULE9, RULE11)
   assign trip_s = sync_q[47:32] | sync_q[31:16];

   // ----------------------------------------------------------------
   // Millisecond divider
   // ----------------------------------------------------------------
   logic [16:0] div_q;                     // Cycle count within a ms
   logic ms_tick_q;                        // One-cycle tick

   // Slow rates run from this enable, not from a second clock
   // The tick follows the wrap, so MS_CYCLES must be two or more
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 17'h0;
         ms_tick_q <= 1'b0;
      end else if (div_q == 17'(MS_CYCLES - 1)) begin
         div_q <= 17'h0;
         ms_tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 17'h1;
         ms_tick_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [15:0] cmd_q;                     // Commanded values
   logic [1:0] cfg_q;                      // Monitor enables
   logic [15:0] rpi_q;                     // requested_packet_interval
   logic [NEV-1:0] ists_q;                 // Sticky events
   logic [NEV-1:0] imsk_q;                 // Event mask
   logic wr_pend_q;                        // Write data phase due
   logic [AW-1:0] wr_addr_q;               // Write target
   logic acc;                              // Address phase taken
   logic rd_ists;                          // Status read this cycle
   logic [NEV-1:0] ev;                     // Events this cycle

   // Word select from the low address bits
   function automatic logic [31:0] read_mux(input logic [AW-1:0] a);
      case (a)
         OFS_CMD: read_mux = {16'h0, cmd_q};
         OFS_CFG: read_mux = {30'h0, cfg_q};
         OFS_RPI: read_mux = {16'h0, rpi_q};
         OFS_ECHO: read_mux = {16'h0, pt_drive};
         OFS_OPEN: read_mux = {16'h0, point_open_load_flag};
         OFS_OVC: read_mux = {16'h0, point_overcurrent_flag};
         OFS_PWR: read_mux = {16'h0, point_power_fault};
         OFS_ISTS: read_mux = {28'h0, ists_q};
         OFS_IMSK: read_mux = {28'h0, imsk_q};
         default: read_mux = 32'h0;        // Unmapped reads zero
      endcase
   endfunction

   // A transfer is taken only when selected, ready and not idle
   assign acc = hsel && hready && htrans[1];
   assign rd_ists = acc && !hwrite && haddr[AW-1:0] == OFS_ISTS;

   // Zero-wait slave; read data captured in the address phase
   // Ready and response never change but stay in flops for clean outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= acc && hwrite;
         if (acc) begin
            wr_addr_q <= haddr[AW-1:0];
         end
         if (acc && !hwrite) begin
            hrdata <= read_mux(haddr[AW-1:0]);
         end
      end
   end

   // Writable registers, written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_q <= 16'h0;
         cfg_q <= CFG_RST;                 // see RULE6
         rpi_q <= RPI_RST;
         imsk_q <= '0;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            OFS_CMD: cmd_q <= hwdata[15:0];
            OFS_CFG: cfg_q <= hwdata[1:0];  // see RULE4, RULE6
            // Zero would also send on every tick; hold at one ms instead
            OFS_RPI: rpi_q <= (hwdata[15:0] == 16'h0) ? 16'h1 : hwdata[15:0];
            OFS_IMSK: imsk_q <= hwdata[NEV-1:0];
            default: ;                     // Read-only or unmapped
         endcase
      end
   end

   // Sticky events; a set in the clearing read cycle is kept
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ists_q <= '0;
      end else begin
         ists_q <= (rd_ists ? '0 : ists_q) | ev;
      end
   end

   // Interrupt output from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ists_q & imsk_q);
      end
   end

   // ----------------------------------------------------------------
   // Point drive and faults
   // ----------------------------------------------------------------
   point_diag_if pd ();
   logic [15:0] open_new;                  // Rising open-load flags
   logic [15:0] ovc_new;                   // Rising overcurrent flags
   logic [15:0] pwr_new;                   // Rising power-loss flags
   logic pkt_due;                          // Packet interval reached

   // Tripped points are forced off, others follow the command
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pt_drive <= 16'h0;
         led_red <= 16'h0;
         point_overcurrent_flag <= 16'h0;
      end else begin
         pt_drive <= cmd_q & ~trip_s;      // see RULE9, RULE10, RULE11, RULE12
         led_red <= trip_s;                // see RULE9, RULE10, RULE11, RULE12
         point_overcurrent_flag <= trip_s; // see RULE9, RULE10, RULE11, RULE12
      end
   end

   // Supply loss hits every point; gated by the monitor enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         point_power_fault <= 16'h0;
      end else begin
         // One supply sense feeds every point (see RULE3, RULE4)
         point_power_fault <= {NPTS{cfg_q[CFG_PWR_MON] && !pwr_ok_s}};
      end
   end

   assign pd.ms_tick = ms_tick_q;
   assign pd.open_en = cfg_q[CFG_OPEN_EN];
   assign pd.drive = pt_drive;             // Off means actually driven off
   assign pd.sense = sync_q[15:0];

   open_load_timer u_timer (
      .hclk (hclk),
      .hresetn (hresetn),
      .pd (pd)
   );

   // Flag reads one while the qualified condition holds (see RULE8)
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         point_open_load_flag <= 16'h0;
      end else begin
         point_open_load_flag <= pd.qual;  // see RULE5, RULE7, RULE8
      end
   end

   // Rising edges only; a fault that stays set raises no second event
   assign open_new = pd.qual & ~point_open_load_flag;
   assign ovc_new = trip_s & ~point_overcurrent_flag;
   assign pwr_new = {NPTS{cfg_q[CFG_PWR_MON] && !pwr_ok_s}} &
                    ~point_power_fault;

   // ----------------------------------------------------------------
   // Status packets
   // ----------------------------------------------------------------
   logic [15:0] rpi_cnt_q;                 // Ms since last packet

   // Compare count+1 so an interval of one ms sends on every tick
   assign pkt_due = ms_tick_q && rpi_cnt_q + 16'h1 >= rpi_q;

   // Interval counter in milliseconds
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rpi_cnt_q <= 16'h0;
      end else if (pkt_due) begin
         rpi_cnt_q <= 16'h0;
      end else if (ms_tick_q) begin
         rpi_cnt_q <= rpi_cnt_q + 16'h1;
      end
   end

   // Snapshot echo and status together each interval (see RULE1, RULE2)
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         packet_strobe <= 1'b0;
         packet_echo <= 16'h0;
         packet_open_load <= 16'h0;
         packet_overcurrent <= 16'h0;
         packet_power_fault <= 16'h0;
      end else begin
         packet_strobe <= pkt_due;
         if (pkt_due) begin
            packet_echo <= pt_drive;       // see RULE1
            packet_open_load <= point_open_load_flag; // see RULE2
            packet_overcurrent <= point_overcurrent_flag;
            packet_power_fault <= point_power_fault;
         end
      end
   end

   // Events that set the sticky status bits
   assign ev[IEV_PACKET] = pkt_due;
   assign ev[IEV_OPEN] = |open_new;
   assign ev[IEV_OVC] = |ovc_new;
   assign ev[IEV_PWR] = |pwr_new;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_trip_forces_off: assert property ( // see RULE9
      1 |=> (pt_drive & $past(trip_s)) == 16'h0)
      else $error("tripped point still driven");
   a_resume_command: assert property ( // see RULE10
      $fell(point_overcurrent_flag[0]) |-> pt_drive[0] == $past(cmd_q[0]))
      else $error("point did not resume commanded value");
   a_short_sets_flag: assert property ( // see RULE9
      sync_q[32] |=> led_red[0] && point_overcurrent_flag[0] && !pt_drive[0])
      else $error("short did not light indicator and flag");
   a_led_with_flag: assert property ( // see RULE11
      sync_q[17] |=> led_red[1] && point_overcurrent_flag[1] && !pt_drive[1])
      else $error("thermal trip did not light indicator and flag");
   a_clear_on_end: assert property ( // see RULE12
      !trip_s[0] ##1 !trip_s[0] |=> !led_red[0] && !point_overcurrent_flag[0])
      else $error("indicator or flag not cleared");
   a_echo_snapshot: assert property ( // see RULE1
      packet_strobe |-> packet_echo == $past(pt_drive))
      else $error("echo differs from applied value");
   a_packet_on_tick: assert property ( // see RULE2
      packet_strobe |-> $past(ms_tick_q) ##1 !packet_strobe)
      else $error("packet strobe off the interval tick");
   a_power_all_points: assert property ( // see RULE3
      cfg_q[CFG_PWR_MON] && !pwr_ok_s |=> point_power_fault == 16'hffff)
      else $error("power loss not flagged on every point");
   a_power_gated: assert property ( // see RULE4
      !cfg_q[CFG_PWR_MON] |=> point_power_fault == 16'h0)
      else $error("power loss flagged while monitor off");
   a_open_load_gated: assert property ( // see RULE6
      !cfg_q[CFG_OPEN_EN] ##1 !cfg_q[CFG_OPEN_EN] |=>
      point_open_load_flag == 16'h0)
      else $error("open load flagged while check off");
   a_open_load_off: assert property ( // see RULE5
      point_open_load_flag[0] |-> !$past(pt_drive[0], 2))
      else $error("open load flagged on a driven point");
   a_sticky_read: assert property ( // see RULE2
      pkt_due && rd_ists |=> ists_q[IEV_PACKET])
      else $error("event lost in clearing read");
   a_status_clear: assert property ( // see RULE2
      rd_ists && !ev[IEV_PACKET] |=> !ists_q[IEV_PACKET])
      else $error("status bit not cleared by read");

   c_short_trip: cover property ($rose(point_overcurrent_flag[0]));
   c_open_load: cover property ($rose(point_open_load_flag[0]));
   c_packet: cover property (packet_strobe ##[1:1000] !packet_strobe);
   c_irq: cover property ($rose(irq));
   c_thermal_trip: cover property (
      $rose(sync_q[17]) ##1 point_overcurrent_flag[1]);
endmodule

/* File: field_model.sv */
/*
 Field-side model: supply, fault senses and load wiring of 16 points.
 Assumes the bench sets the fault causes and watches the terminal drive.
*/
`timescale 1ns/1ps
module field_model (
   input wire logic [15:0] drive,     // Terminal drive
   input wire logic supply_on,        // Field supply present
   input wire logic [15:0] wire_cut,  // Load missing
   input wire logic [15:0] shorted,   // Shorted load
   input wire logic [15:0] hot,       // Overheated switch
   output logic field_power_ok,       // Supply sense
   output logic [15:0] short_det,     // Short sense
   output logic [15:0] over_temp,     // Thermal sense
   output logic [15:0] open_sense     // Open-load sense
);
   // Senses follow their causes; the design syncs them itself
   assign field_power_ok = supply_on;
   assign short_det = shorted;
   assign over_temp = hot;
   // A missing load only shows while the switch is off
   assign open_sense = wire_cut & ~drive;
endmodule

/* File: tb_top.sv */
/*
 Self-checking bench for the output point diagnostics block.
 Assumes the field model on the pins and one AHB-Lite slave on the bus.
*/
`timescale 1ns/1ps
module tb_top;
   import diag_pkg::*;
   localparam int MSC = 10; // Shortened millisecond
   logic hclk, hresetn, hsel, hwrite; // Bus controls
   logic [31:0] haddr, hwdata, hrdata, rd; // Bus data
   logic [1:0] htrans; // Transfer type
   logic [2:0] hsize; // Word size
   logic hready, hresp, fpo, strobe, irq; // Single-bit lines
   logic sup; // Field supply
   logic [15:0] cut, sht, hot, sd, ot, os, drv, led, opn, ovc, pwf; // Pins
   logic [15:0] pe, po, pc, pp; // Packet snapshots
   int err_total, n_compared, n; // Counters
   // ----------------------------------------------------------------
   // Design and field
   // ----------------------------------------------------------------
   output_point_diagnostics #(.MS_CYCLES(MSC)) DUT (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .field_power_ok(fpo), .short_det(sd), .over_temp(ot),
      .open_sense(os), .pt_drive(drv), .led_red(led),
      .point_open_load_flag(opn), .point_overcurrent_flag(ovc),
      .point_power_fault(pwf), .packet_strobe(strobe),
      .packet_echo(pe), .packet_open_load(po),
      .packet_overcurrent(pc), .packet_power_fault(pp), .irq(irq));
   field_model fm (.drive(drv), .supply_on(sup), .wire_cut(cut),
      .shorted(sht), .hot(hot), .field_power_ok(fpo), .short_det(sd),
      .over_temp(ot), .open_sense(os));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One single transfer; the address phase waits for ready
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      // Select stays up; the next call may start in this time step
   endtask
   task automatic ms(int k);
      repeat (k * MSC) @(posedge hclk);
   endtask
   task automatic wait_pkt();
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (strobe !== 1'b1 && n < 2000);
      if (strobe !== 1'b1) err_total++; // Limit ran out
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // The tests take about 5400 cycles; this is ample margin
   initial begin
      #500us;
      err_total++;
      give_verdict();
   end
   initial begin
      err_total = 0;
      n_compared = 0;
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      sup = 1'b1;
      {cut, sht, hot} = '0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values, unmapped place
      bus(0, OFS_CFG, 0); chk("cfg", rd, 0);
      bus(0, OFS_RPI, 0); chk("rpi", rd, 32'(RPI_RST));
      bus(0, 8'h40, 0); chk("unmapped", rd, 0);
      // Echo of applied values, back to back with a read
      bus(1, OFS_CMD, 32'h0000a5c3);
      bus(0, OFS_ECHO, 0);
      repeat (3) @(posedge hclk);
      chk("drive", drv, 16'ha5c3);
      bus(0, OFS_ECHO, 0); chk("echo", rd, 32'h0000a5c3);
      chk("resp", hresp, 0);
      // Packet interval and snapshot
      bus(1, OFS_RPI, 2);
      bus(1, OFS_IMSK, 32'h00000001);
      wait_pkt();
      wait_pkt();
      chk("pkt_echo", pe, 16'ha5c3);
      wait_pkt();
      chk("pkt_gap", n, 2 * MSC);
      @(posedge hclk);
      @(posedge hclk);
      chk("irq_on", irq, 1);
      bus(0, OFS_ISTS, 0); chk("ists", rd & 1, 1);
      @(posedge hclk);
      chk("irq_off", irq, 0);
      // A clearing read that meets a packet event must keep the event
      wait_pkt();
      repeat (2 * MSC - 2) @(posedge hclk);
      bus(0, OFS_ISTS, 0);
      bus(0, OFS_ISTS, 0); chk("ists_kept", rd & 1, 1);
      bus(1, OFS_IMSK, 0);
      // Power loss, monitor off then on
      sup <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("pwr_off", pwf, 0);
      bus(1, OFS_CFG, 32'h00000001);
      repeat (4) @(posedge hclk);
      chk("pwr_on", pwf, 16'hffff);
      wait_pkt();
      chk("pkt_pwr", pp, 16'hffff);
      sup <= 1'b1;
      // Short on point 0, heat on point 1, then both clear
      sht <= 16'h0001;
      hot <= 16'h0002;
      repeat (5) @(posedge hclk);
      chk("trip_drv", drv, 16'ha5c0);
      chk("trip_led", led, 16'h0003);
      chk("trip_flag", ovc, 16'h0003);
      bus(0, OFS_OVC, 0); chk("ovc_reg", rd, 32'h00000003);
      wait_pkt();
      chk("pkt_ovc", pc, 16'h0003);
      sht <= 16'h0000;
      hot <= 16'h0000;
      repeat (5) @(posedge hclk);
      chk("rec_drv", drv, 16'ha5c3);
      chk("rec_led", led, 0);
      chk("rec_flag", ovc, 0);
      // Open load: check off, then qualified off time
      cut <= 16'hffff;
      bus(1, OFS_CMD, 32'h000000ff);
      ms(260);
      chk("open_dis", opn, 0);
      bus(1, OFS_CMD, 32'h0000ffff);
      ms(2);
      bus(1, OFS_CMD, 32'h000000ff);
      bus(1, OFS_CFG, 32'h00000002);
      ms(240);
      chk("open_early", opn, 0);
      ms(15);
      chk("open_flag", opn, 16'hff00);
      bus(0, OFS_OPEN, 0); chk("open_reg", rd, 32'h0000ff00);
      wait_pkt();
      chk("pkt_open", po, 16'hff00);
      give_verdict();
   end
endmodule
